// ---- cfg_host.sv ----
// host model: drives register frames on the three-wire serial port
`timescale 1ns/1ps
module cfg_host
(
  // serial port
  output logic serial_clock,
  output logic serial_input_line,
  output logic serial_select_n
);
  // idle: clock stands still, port deselected
  initial
  begin
    serial_clock      = 1'b0;
    serial_input_line = 1'b1;
    serial_select_n   = 1'b1;
  end
  // msb first, select may stay low
  task automatic send(input logic [31:0] frame, input bit keep);
    serial_select_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      serial_input_line = frame[i];
      #160 serial_clock = 1'b1;
      #160 serial_clock = 1'b0;
    end
    if (!keep)
    begin
      serial_select_n   = 1'b1;
      serial_input_line = ~serial_input_line; // no stale bit
    end
  endtask
endmodule // cfg_host

// ---- conv_ctrl_pkg.sv ----
// package: register map, reset values, field positions, frame layout and clock-stage states of the control bank
package conv_ctrl_pkg;

  // register addresses (4-bit frame address)
  localparam logic [3:0] ADDR_OUTPUT_CONFIGURATION      = 4'h1;
  localparam logic [3:0] ADDR_FIRST_CHANNEL_OFFSET      = 4'h2;
  localparam logic [3:0] ADDR_FIRST_CHANNEL_FULL_SCALE  = 4'h3;
  localparam logic [3:0] ADDR_SECOND_CHANNEL_OFFSET     = 4'hA;
  localparam logic [3:0] ADDR_SECOND_CHANNEL_FULL_SCALE = 4'hB;
  localparam logic [3:0] ADDR_INTERLEAVE_ENABLE         = 4'hD;
  localparam logic [3:0] ADDR_INTERLEAVE_COARSE_SKEW    = 4'hE;
  localparam logic [3:0] ADDR_INTERLEAVE_FINE_SKEW      = 4'hF;

  // power-on values
  localparam logic [15:0] RST_OUTPUT_CONFIGURATION = 16'hB2FF;
  localparam logic [15:0] RST_CHANNEL_OFFSET       = 16'h007F;
  localparam logic [15:0] RST_CHANNEL_FULL_SCALE   = 16'h807F;
  localparam logic [15:0] RST_INTERLEAVE_ENABLE    = 16'h3FFF;
  localparam logic [15:0] RST_INTERLEAVE_COARSE    = 16'h07FF;
  localparam logic [15:0] RST_INTERLEAVE_FINE      = 16'h007F;

  // frame layout
  localparam int           FRAME_BITS   = 32;
  localparam logic [11:0]  FRAME_HEADER = 12'h001;

  // configuration field positions
  localparam int CFG_DCS_BIT   = 12;
  localparam int CFG_PHASE_BIT = 11;
  localparam int CFG_SDR_BIT   = 10;
  localparam int CFG_SWING_BIT = 9;
  localparam int CFG_EDGE_BIT  = 8;

  // offset, full-scale and skew field positions
  localparam int OFS_MAG_MSB   = 15;
  localparam int OFS_MAG_LSB   = 8;
  localparam int OFS_SIGN_BIT  = 7;
  localparam int FS_MSB        = 15;
  localparam int FS_LSB        = 7;
  localparam int ILV_ON_BIT    = 15;
  localparam int ILV_AUTO_BIT  = 14;
  localparam int SKEW_INP_BIT  = 15;
  localparam int SKEW_TGT_BIT  = 14;
  localparam int COARSE_MSB    = 13;
  localparam int COARSE_LSB    = 11;
  localparam int FINE_MSB      = 15;
  localparam int FINE_LSB      = 7;

  // reset value of the channel full-scale trims
  localparam logic [8:0] FS_NOMINAL = 9'h100;

  // output clock stage state
  typedef enum logic [1:0] {
    OCLK_RUN    = 2'b00,
    OCLK_HOLD   = 2'b01,
    OCLK_ARMED  = 2'b10
  } oclk_state_t;

endpackage : conv_ctrl_pkg

// ---- conv_ctrl_regs.sv ----
// extended control register bank and output clock realignment of a dual converter
`timescale 1ns/1ps
module conv_ctrl_regs
  import conv_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // mode and normal-mode pins
  input  wire logic        extended_mode,
  input  wire logic        edge_select_pin,
  input  wire logic        swing_select_pin,
  input  wire logic        interleave_pin,
  // serial port
  input  wire logic        serial_clock,
  input  wire logic        serial_input_line,
  input  wire logic        serial_select_n,
  // sample clock and realignment
  input  wire logic        sample_clock,
  input  wire logic        output_clock_realign,
  input  wire logic        calibration_running,
  // output clock stage
  output logic             output_data_clock,
  output logic             realign_holding,
  output logic             single_rate_output,
  // effective controls
  output logic             duty_cycle_stabilizer_on,
  output logic             double_rate_clock_phase,
  output logic             output_swing_select,
  output logic             output_edge_rising,
  output logic [7:0]       first_offset_magnitude,
  output logic             first_offset_negative,
  output logic [8:0]       first_full_scale,
  output logic [7:0]       second_offset_magnitude,
  output logic             second_offset_negative,
  output logic [8:0]       second_full_scale,
  output logic             interleave_on,
  output logic             auto_phase_control,
  output logic             interleave_input_choice,
  output logic             skew_target_select,
  output logic [2:0]       coarse_skew_value,
  output logic [8:0]       fine_skew_value,
  output logic             calibration_fault
);

  import conv_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers

  logic [1:0] rst_sync;
  logic       rst_n;
  logic [1:0] mode_sync;
  logic [1:0] sclk_sync;
  logic [1:0] sdi_sync;
  logic [1:0] scs_sync;
  logic [1:0] samp_sync;
  logic [1:0] rea_sync;
  logic [1:0] cal_sync;
  logic [1:0] edge_sync;
  logic [1:0] swing_sync;
  logic [1:0] ilv_sync;

  assign rst_n = rst_sync[1];

  // reset enters asynchronously, leaves synchronously
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // two-stage synchronisers for every outside input
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_sync  <= 2'b00;
      sclk_sync  <= 2'b00;
      sdi_sync   <= 2'b00;
      scs_sync   <= 2'b11;
      samp_sync  <= 2'b00;
      rea_sync   <= 2'b00;
      cal_sync   <= 2'b00;
      edge_sync  <= 2'b00;
      swing_sync <= 2'b00;
      ilv_sync   <= 2'b00;
    end
    else
    begin
      mode_sync  <= {mode_sync[0], extended_mode};
      sclk_sync  <= {sclk_sync[0], serial_clock};
      sdi_sync   <= {sdi_sync[0], serial_input_line};
      scs_sync   <= {scs_sync[0], serial_select_n};
      samp_sync  <= {samp_sync[0], sample_clock};
      rea_sync   <= {rea_sync[0], output_clock_realign};
      cal_sync   <= {cal_sync[0], calibration_running};
      edge_sync  <= {edge_sync[0], edge_select_pin};
      swing_sync <= {swing_sync[0], swing_select_pin};
      ilv_sync   <= {ilv_sync[0], interleave_pin};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial frame reception

  logic        frame_valid;
  logic [3:0]  frame_addr;
  logic [15:0] frame_data;

  serial_frame_rx u_rx (
    .mclk                (mclk),
    .rst_n               (rst_n),
    .sclk_s              (sclk_sync[1]),
    .serial_input_line_s (sdi_sync[1]),
    .serial_select_n_s   (scs_sync[1]),
    .port_enable         (mode_sync[1]),
    .frame_valid         (frame_valid),
    .frame_addr          (frame_addr),
    .frame_data          (frame_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register bank

  logic [15:0] output_configuration;
  logic [15:0] first_channel_offset;
  logic [15:0] first_channel_full_scale;
  logic [15:0] second_channel_offset;
  logic [15:0] second_channel_full_scale;
  logic [15:0] interleave_enable;
  logic [15:0] interleave_coarse_skew;
  logic [15:0] interleave_fine_skew;

  function automatic logic hit(input logic [3:0] a);
    hit = frame_valid && (frame_addr == a);
  endfunction

  // defaults at reset; only mapped addresses written
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      output_configuration      <= RST_OUTPUT_CONFIGURATION;
      first_channel_offset      <= RST_CHANNEL_OFFSET;
      first_channel_full_scale  <= RST_CHANNEL_FULL_SCALE;
      second_channel_offset     <= RST_CHANNEL_OFFSET;
      second_channel_full_scale <= RST_CHANNEL_FULL_SCALE;
      interleave_enable         <= RST_INTERLEAVE_ENABLE;
      interleave_coarse_skew    <= RST_INTERLEAVE_COARSE;
      interleave_fine_skew      <= RST_INTERLEAVE_FINE;
    end
    else
    begin
      if (hit(ADDR_OUTPUT_CONFIGURATION))
        output_configuration <= frame_data;
      if (hit(ADDR_FIRST_CHANNEL_OFFSET))
        first_channel_offset <= frame_data;
      if (hit(ADDR_FIRST_CHANNEL_FULL_SCALE))
        first_channel_full_scale <= frame_data;
      if (hit(ADDR_SECOND_CHANNEL_OFFSET))
        second_channel_offset <= frame_data;
      if (hit(ADDR_SECOND_CHANNEL_FULL_SCALE))
        second_channel_full_scale <= frame_data;
      if (hit(ADDR_INTERLEAVE_ENABLE))
        interleave_enable <= frame_data;
      if (hit(ADDR_INTERLEAVE_COARSE_SKEW))
        interleave_coarse_skew <= frame_data;
      if (hit(ADDR_INTERLEAVE_FINE_SKEW))
        interleave_fine_skew <= frame_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective controls, normal mode falls back to pins and defaults

  logic ext;
  assign ext = mode_sync[1];

  logic [15:0] dflt_cfg;
  assign dflt_cfg = RST_OUTPUT_CONFIGURATION;
  logic [15:0] dflt_fs;
  assign dflt_fs = RST_CHANNEL_FULL_SCALE;

  // register contents apply only in extended mode
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      duty_cycle_stabilizer_on <= 1'b0;
      double_rate_clock_phase  <= 1'b0;
      single_rate_output       <= 1'b0;
      output_swing_select      <= 1'b0;
      output_edge_rising       <= 1'b0;
    end
    else if (ext)
    begin
      duty_cycle_stabilizer_on <= output_configuration[CFG_DCS_BIT];
      double_rate_clock_phase  <= !output_configuration[CFG_SDR_BIT]
                                  && output_configuration[CFG_PHASE_BIT];
      single_rate_output       <= output_configuration[CFG_SDR_BIT];
      output_swing_select      <= output_configuration[CFG_SWING_BIT];
      output_edge_rising       <= output_configuration[CFG_EDGE_BIT];
    end
    else
    begin
      duty_cycle_stabilizer_on <= dflt_cfg[CFG_DCS_BIT];
      double_rate_clock_phase  <= 1'b0;
      single_rate_output       <= 1'b1;
      output_swing_select      <= swing_sync[1];
      output_edge_rising       <= edge_sync[1];
    end
  end

  // channel trims
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_offset_magnitude  <= 8'h00;
      first_offset_negative   <= 1'b0;
      first_full_scale        <= FS_NOMINAL;
      second_offset_magnitude <= 8'h00;
      second_offset_negative  <= 1'b0;
      second_full_scale       <= FS_NOMINAL;
    end
    else if (ext)
    begin
      // magnitude and sign, both taken from the offset registers
      first_offset_magnitude  <= first_channel_offset[OFS_MAG_MSB:OFS_MAG_LSB];
      first_offset_negative   <= first_channel_offset[OFS_SIGN_BIT];
      second_offset_magnitude <= second_channel_offset[OFS_MAG_MSB:OFS_MAG_LSB];
      second_offset_negative  <= second_channel_offset[OFS_SIGN_BIT];
      first_full_scale        <= first_channel_full_scale[FS_MSB:FS_LSB];
      second_full_scale       <= second_channel_full_scale[FS_MSB:FS_LSB];
    end
    else
    begin
      first_offset_magnitude  <= 8'h00;
      first_offset_negative   <= 1'b0;
      first_full_scale        <= dflt_fs[FS_MSB:FS_LSB];
      second_offset_magnitude <= 8'h00;
      second_offset_negative  <= 1'b0;
      second_full_scale       <= dflt_fs[FS_MSB:FS_LSB];
    end
  end

  // interleave controls
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      interleave_on           <= 1'b0;
      auto_phase_control      <= 1'b0;
      interleave_input_choice <= 1'b0;
      skew_target_select      <= 1'b0;
      coarse_skew_value       <= 3'h0;
      fine_skew_value         <= 9'h000;
    end
    else if (ext)
    begin
      interleave_on           <= interleave_enable[ILV_ON_BIT];
      auto_phase_control      <= interleave_enable[ILV_AUTO_BIT];
      interleave_input_choice <= interleave_coarse_skew[SKEW_INP_BIT];
      skew_target_select      <= interleave_coarse_skew[SKEW_TGT_BIT];
      coarse_skew_value       <= interleave_enable[ILV_AUTO_BIT] ? 3'h0
                                 : interleave_coarse_skew[COARSE_MSB:COARSE_LSB];
      fine_skew_value         <= interleave_enable[ILV_AUTO_BIT] ? 9'h000
                                 : interleave_fine_skew[FINE_MSB:FINE_LSB];
    end
    else
    begin
      interleave_on           <= ilv_sync[1];
      auto_phase_control      <= 1'b1;
      interleave_input_choice <= 1'b0;
      skew_target_select      <= 1'b0;
      coarse_skew_value       <= 3'h0;
      fine_skew_value         <= 9'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output clock realignment

  logic oclk;
  logic hold;

  // hold and realign the output clock
  output_clock_gen u_oclk (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .sample_clk_s      (samp_sync[1]),
    .realign_s         (rea_sync[1]),
    .single_rate       (single_rate_output),
    .edge_rising       (output_edge_rising),
    .output_data_clock (oclk),
    .holding           (hold)
  );

  // registered copies for the top outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      output_data_clock <= 1'b0;
      realign_holding   <= 1'b0;
    end
    else
    begin
      output_data_clock <= oclk;
      realign_holding   <= hold;
    end
  end

  // flag a realign raised during calibration
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      calibration_fault <= 1'b0;
    else if (rea_sync[1] && cal_sync[1])
      calibration_fault <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_frame;
    frame_valid && frame_addr == ADDR_OUTPUT_CONFIGURATION && ext;
  endsequence

  property p_cfg_apply;
    @(posedge mclk) disable iff (!rst_n)
    s_frame ##1 ext |=> single_rate_output == $past(output_configuration[CFG_SDR_BIT]);
  endproperty
  a_cfg_apply: assert property (p_cfg_apply)
    else $error("configuration not applied");

  property p_normal_ignore;
    @(posedge mclk) disable iff (!rst_n)
    $past(!ext) && $past(rst_n) |-> single_rate_output && !double_rate_clock_phase;
  endproperty
  a_normal_ignore: assert property (p_normal_ignore)
    else $error("register applied in normal mode");

  property p_phase_ddr;
    @(posedge mclk) disable iff (!rst_n)
    double_rate_clock_phase |-> !single_rate_output || $past(!output_configuration[CFG_SDR_BIT]);
  endproperty
  a_phase_ddr: assert property (p_phase_ddr)
    else $error("phase active in single rate");

  property p_ofs;
    @(posedge mclk) disable iff (!rst_n)
    $past(ext) |-> first_offset_magnitude == $past(first_channel_offset[15:8]);
  endproperty
  a_ofs: assert property (p_ofs)
    else $error("offset magnitude mismatch");

  property p_auto;
    @(posedge mclk) disable iff (!rst_n)
    auto_phase_control && $past(ext) |-> coarse_skew_value == 3'h0 && fine_skew_value == 9'h000;
  endproperty
  a_auto: assert property (p_auto)
    else $error("manual skew active under auto phase");

  property p_reserved;
    @(posedge mclk) disable iff (!rst_n)
    frame_valid && frame_addr inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hC}
      |=> $stable({output_configuration, first_channel_offset, interleave_enable});
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved address altered registers");

  property p_hold;
    @(posedge mclk) disable iff (!rst_n)
    rea_sync[1] [*4] |-> realign_holding;
  endproperty
  a_hold: assert property (p_hold)
    else $error("output clock not held");

  property p_cal;
    @(posedge mclk) disable iff (!rst_n)
    rea_sync[1] && cal_sync[1] |=> calibration_fault;
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration fault not flagged");

endmodule // conv_ctrl_regs

// ---- dual_adc_control_regs_and_clock_sync_tb.sv ----
// testbench: serial frames in, effective controls and output clock checked
`timescale 1ns/1ps
module dual_adc_control_regs_and_clock_sync_tb;
  import conv_ctrl_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, extended_mode = 1'b1, sample_clock = 1'b0;
  logic calibration_running = 1'b0;
  logic output_clock_realign = 1'b0, serial_clock, serial_input_line, serial_select_n;
  logic output_data_clock, realign_holding, single_rate_output, duty_cycle_stabilizer_on;
  logic double_rate_clock_phase, output_swing_select, output_edge_rising, interleave_on;
  logic first_offset_negative, second_offset_negative, auto_phase_control, last_clk;
  logic interleave_input_choice, skew_target_select, calibration_fault;
  logic [7:0] first_offset_magnitude, second_offset_magnitude;
  logic [8:0] first_full_scale, second_full_scale, fine_skew_value;
  logic [2:0] coarse_skew_value;
  int n_fail = 0, n_checks = 0, cycles = 0;
  // system clock and free-running sample clock
  always #20 mclk = ~mclk;
  always #200 sample_clock = ~sample_clock;
  conv_ctrl_regs dut_u (.mclk, .rstn, .extended_mode, .edge_select_pin(1'b0),
    .swing_select_pin(1'b1), .interleave_pin(1'b0), .serial_clock, .serial_input_line,
    .serial_select_n, .sample_clock, .output_clock_realign, .calibration_running,
    .output_data_clock, .realign_holding, .single_rate_output, .duty_cycle_stabilizer_on,
    .double_rate_clock_phase, .output_swing_select, .output_edge_rising,
    .first_offset_magnitude, .first_offset_negative, .first_full_scale,
    .second_offset_magnitude, .second_offset_negative, .second_full_scale, .interleave_on,
    .auto_phase_control, .interleave_input_choice, .skew_target_select, .coarse_skew_value,
    .fine_skew_value, .calibration_fault);
  cfg_host host_u (.serial_clock, .serial_input_line, .serial_select_n);
  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one frame; a held select lets the next frame follow at once
  task automatic wr(input logic [11:0] hdr, input logic [3:0] a, input logic [15:0] d,
                    input bit keep = 0);
    host_u.send({hdr, a, d}, keep);
    if (!keep)
      repeat (10) @(negedge mclk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  // test sequence
  initial
  begin
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    repeat (8) @(negedge mclk);
    chk("defaults",
      {duty_cycle_stabilizer_on, double_rate_clock_phase, single_rate_output,
       output_swing_select, output_edge_rising, first_full_scale, interleave_on,
       auto_phase_control, fine_skew_value}, {5'h12, 9'h100, 2'b00, 9'h000});
    $display("test defaults done");
    // fixed low bits written as ones
    wr(FRAME_HEADER, ADDR_OUTPUT_CONFIGURATION, 16'hACFF);
    wr(FRAME_HEADER, ADDR_FIRST_CHANNEL_OFFSET, 16'h00FF, 1); // chained
    wr(FRAME_HEADER, ADDR_SECOND_CHANNEL_OFFSET, 16'hFF7F);
    wr(FRAME_HEADER, ADDR_FIRST_CHANNEL_FULL_SCALE, 16'h607F);
    wr(FRAME_HEADER, ADDR_SECOND_CHANNEL_FULL_SCALE, 16'hE07F);
    wr(FRAME_HEADER, ADDR_INTERLEAVE_ENABLE, 16'hBFFF);
    wr(FRAME_HEADER, ADDR_INTERLEAVE_COARSE_SKEW, 16'hDFFF);
    wr(FRAME_HEADER, ADDR_INTERLEAVE_FINE_SKEW, 16'hFFFF);
    wr(FRAME_HEADER, 4'h4, 16'h0000); // reserved
    wr(12'h003, ADDR_OUTPUT_CONFIGURATION, 16'hB2FF); // bad header
    chk("cfg", {duty_cycle_stabilizer_on, double_rate_clock_phase,
      single_rate_output, output_swing_select, output_edge_rising}, 5'h04);
    chk("offsets", {first_offset_magnitude, first_offset_negative,
      second_offset_magnitude, second_offset_negative}, {9'h001, 9'h1FE});
    chk("scale", {first_full_scale, second_full_scale}, {9'h0C0, 9'h1C0});
    chk("skew", {interleave_on, auto_phase_control, interleave_input_choice,
      skew_target_select, coarse_skew_value, fine_skew_value},
      {7'h5B, 9'h1FF});
    $display("test writes done");
    extended_mode = 1'b0;
    wr(FRAME_HEADER, ADDR_OUTPUT_CONFIGURATION, 16'hB2FF); // muted
    chk("normal", {single_rate_output, output_swing_select}, 2'b11); // fixed single rate, swing from its pin
    extended_mode = 1'b1;
    repeat (4) @(negedge mclk);
    chk("ext", duty_cycle_stabilizer_on, 1'b0); // port muted
    $display("test mode done");
    output_clock_realign = 1'b1; // calibration idle
    repeat (12) @(negedge mclk);
    chk("hold", {realign_holding, output_data_clock}, 2'b11); // single rate
    @(posedge sample_clock);
    output_clock_realign = 1'b0; // synchronous release
    repeat (16) @(negedge mclk);
    last_clk = output_data_clock;
    chk("release", {realign_holding, calibration_fault}, 2'b00);
    repeat (10) @(negedge mclk);
    chk("toggle", output_data_clock, {~last_clk}); // toggling
    $display("test realign done");
    wr(FRAME_HEADER, ADDR_INTERLEAVE_ENABLE, 16'hFFFF);
    chk("auto", {auto_phase_control, coarse_skew_value, fine_skew_value},
      {1'b1, 12'h000});
    $display("test auto phase done");
    wr(FRAME_HEADER, ADDR_OUTPUT_CONFIGURATION, 16'hA9FF); // double rate
    chk("ddr", {duty_cycle_stabilizer_on, double_rate_clock_phase,
      single_rate_output, output_swing_select, output_edge_rising}, 5'h09);
    calibration_running = 1'b1;
    output_clock_realign = 1'b1; // host breaks the calibration rule on purpose
    repeat (12) @(negedge mclk);
    chk("ddr hold", {realign_holding, output_data_clock, calibration_fault}, 3'b101);
    $display("test double rate done");
    tally_and_finish();
  end
endmodule // dual_adc_control_regs_and_clock_sync_tb

// ---- output_clock_gen.sv ----
// output data clock generator with realignment hold
`timescale 1ns/1ps
module output_clock_gen
  import conv_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // synchronised sample clock and realign request
  input  wire logic        sample_clk_s,
  input  wire logic        realign_s,
  // mode
  input  wire logic        single_rate,
  input  wire logic        edge_rising,
  // output clock
  output logic             output_data_clock,
  output logic             holding
);

  oclk_state_t state;
  logic        samp_d;
  logic        fall;
  logic        hold_level;

  assign fall = samp_d && !sample_clk_s;
  // fixed level while held depends on rate mode and edge choice
  assign hold_level = single_rate ? !edge_rising : 1'b0;

  // sample clock edge history
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      samp_d <= 1'b0;
    else
      samp_d <= sample_clk_s;
  end

  // hold while asserted, arm on release, restart on the next falling edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= OCLK_RUN;
    else if (realign_s)
      state <= OCLK_HOLD;
    else
      unique case (state)
        OCLK_RUN:   state <= OCLK_RUN;
        OCLK_HOLD:  state <= OCLK_ARMED;
        OCLK_ARMED: state <= fall ? OCLK_RUN : OCLK_ARMED;
        default:    state <= OCLK_RUN;
      endcase
  end

  // half-rate output clock toggling on each sample clock falling edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      output_data_clock <= 1'b0;
    else if (state != OCLK_RUN)
      output_data_clock <= hold_level;
    else if (fall)
      output_data_clock <= !output_data_clock;
  end

  // realignment status
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      holding <= 1'b0;
    else
      holding <= (state != OCLK_RUN);
  end

endmodule // output_clock_gen

// ---- serial_frame_rx.sv ----
// serial frame receiver: samples the three-wire port on its rising clock edges
`timescale 1ns/1ps
module serial_frame_rx
  import conv_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // synchronised serial lines
  input  wire logic        sclk_s,
  input  wire logic        serial_input_line_s,
  input  wire logic        serial_select_n_s,
  input  wire logic        port_enable,
  // decoded frame
  output logic             frame_valid,
  output logic [3:0]       frame_addr,
  output logic [15:0]      frame_data
);

  logic        sclk_d;
  logic [31:0] shift;
  logic [5:0]  count;
  logic        rise;

  assign rise = sclk_s && !sclk_d;

  // edge detector on the synchronised serial clock
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sclk_d <= 1'b0;
    else
      sclk_d <= sclk_s;
  end

  // shift in msb first, restart after every 32nd edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift <= 32'h0000_0000;
      count <= 6'h00;
    end
    else if (!port_enable || serial_select_n_s)
      count <= 6'h00;
    else if (rise)
    begin
      shift <= {shift[30:0], serial_input_line_s};
      count <= (count == 6'(FRAME_BITS - 1)) ? 6'h00 : count + 6'h01;
    end
  end

  // one-cycle pulse per complete frame with the right header
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_valid <= 1'b0;
      frame_addr  <= 4'h0;
      frame_data  <= 16'h0000;
    end
    else
    begin
      frame_valid <= 1'b0;
      if (port_enable && !serial_select_n_s && rise && count == 6'(FRAME_BITS - 1)
          && shift[30:19] == FRAME_HEADER)
      begin
        frame_valid <= 1'b1;
        frame_addr  <= shift[18:15];
        frame_data  <= {shift[14:0], serial_input_line_s};
      end
    end
  end

endmodule // serial_frame_rx
